// ==== rtl/wrnc_top.v ====
// Two-wire slave, wiper setting register and fuse store control.
// Assumes open-drain pads outside; address pin pre-decoded to 4 levels.
`timescale 1ns/10ps
`include "wrnc_regs.vh"

// Overview of operation
// [RL1] Reset pin low reloads the wiper from the fuse store memory.
// [RL2] Before any fuse is programmed, restores load the midscale code.
// [RL3] Serial clock and data shift frames through a 16-bit register.
// [RL4] Data line is open drain: pull low or release, never drive high.
// [RL5] Address select pin supplies the two low slave address bits.
// [RL6] Wiper setting register directly drives the wiper position output.
// [RL7] Wiper register is a scratchpad, rewritable without limit.
// [RL8] Stored fuse value is restored at every later power-up.
// [RL9] Fuse store takes 350 ms; device refuses acknowledge and changes. Code still acknowledges and runs further bytes in the store's own frame.
// [RL10] Master polls with address acknowledge to detect store completion.
// [RL11] Upper five slave address bits are fixed at 01011.
// [RL12] Command 0001 in bits 13..10 loads data bits into the wiper.
// [RL13] Fuse store runs only with the program enable bit set.
// [RL14] With the unlock bit clear, wiper writes are ignored.
module wrnc_top #(
  parameter STORE_CYC = `WRNC_STORE_CYC
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // Hardware restore pin, active low
  input  wire        restore_n,
  // Address select, already resolved to A1 A0
  input  wire [1:0]  addr_sel,
  // Two-wire bus
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  // Wiper position and status
  output reg  [9:0]  wiper_pos,         // Drives the wiper directly [RL6]
  output wire        store_busy
);

  localparam ST_IDLE = 6'b000001;
  localparam ST_ADDR = 6'b000010;
  localparam ST_AACK = 6'b000100;
  localparam ST_WR   = 6'b001000;
  localparam ST_DACK = 6'b010000;
  localparam ST_RD   = 6'b100000;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire [4:0] sync_q;
  wrnc_sync #(.W(5)) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({restore_n, addr_sel, scl_in, sda_in}),
    .dout    (sync_q)
  );
  wire       scl_s = sync_q[1];
  wire       sda_s = sync_q[0];
  wire       rst_pin_n = sync_q[4];

  reg        scl_d;
  reg        sda_d;
  reg  [1:0] addr_lo;
  wire       scl_rise = scl_s & ~scl_d;
  wire       scl_fall = ~scl_s & scl_d;
  wire       start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire       stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  reg  [5:0]  state;
  reg  [15:0] shreg;          // Frame shift register [RL3]
  reg  [3:0]  bitcnt;
  reg         byte_idx;
  reg         rd_mode;
  reg         sda_low;
  reg  [3:0]  ctrl;
  // Fuse store memory: no reset, starts unprogrammed, survives nrst.
  // Declaration values keep it single-driven by the bus engine.
  reg  [9:0]  fuse_val  = `WRNC_MIDSCALE;
  reg         fuse_used = 1'b0;  // Any fuse location programmed yet
  reg  [31:0] store_cnt;
  reg  [3:0]  last_cmd;
  reg         restore_q;

  assign store_busy = (store_cnt != 32'h0);
  assign sda_out    = 1'b0;             // Only ever pulls low [RL4]
  assign sda_oe     = sda_low;          // Released means pull-up wins [RL4]

  // Value that any restore loads; midscale until first fuse [RL2]
  function [9:0] restore_value;
    input       used;
    input [9:0] val;
    begin
      restore_value = used ? val : `WRNC_MIDSCALE;
    end
  endfunction

  // Full 7-bit address match from the fixed high part and the strap
  function addr_hit;
    input [6:0] a;
    input [1:0] lo;
    begin
      addr_hit = (a == {`WRNC_ADDR_HI, lo}); // [RL5] [RL11]
    end
  endfunction

  // ----------------------------------------------------------------
  // Edge history and strap capture after reset release
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!nrst) begin
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      restore_q <= 1'b1;
      addr_lo   <= 2'b00;
    end else begin
      scl_d     <= scl_s;
      sda_d     <= sda_s;
      restore_q <= rst_pin_n;
      addr_lo   <= sync_q[3:2];       // Strap tracked after release [RL5]
    end
  end

  // ----------------------------------------------------------------
  // Bus engine, command execution and fuse store timer
  // ----------------------------------------------------------------
  // Fuse contents survive nrst by intent: nrst stands for power-up, and
  // the wiper is reloaded from them then [RL8].
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      shreg     <= 16'h0000;
      bitcnt    <= 4'h0;
      byte_idx  <= 1'b0;
      rd_mode   <= 1'b0;
      sda_low   <= 1'b0;
      ctrl      <= `WRNC_CTL_RESET;
      store_cnt <= 32'h0;
      last_cmd  <= `WRNC_CMD_NOP;
      wiper_pos <= restore_value(fuse_used, fuse_val); // [RL8] [RL2]
    end else begin
      // Store timer; commit happens when it expires
      if (store_cnt == 32'h1) begin
        fuse_val  <= wiper_pos;
        fuse_used <= 1'b1;
        ctrl[`WRNC_CTL_OK] <= 1'b1;
      end
      if (store_busy)
        store_cnt <= store_cnt - 32'h1;     // Locked for 350 ms [RL9]
      // Restore pin falling edge reloads the wiper when no store is running [RL1]
      if (restore_q & ~rst_pin_n & ~store_busy)
        wiper_pos <= restore_value(fuse_used, fuse_val); // [RL1] [RL2]
      if (start_c) begin
        state    <= ST_ADDR;
        bitcnt   <= 4'h0;
        byte_idx <= 1'b0;
        sda_low  <= 1'b0;
      end else if (stop_c) begin
        state   <= ST_IDLE;
        sda_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_low <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg  <= {shreg[14:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              // No acknowledge while storing; master polls [RL9] [RL10]
              if (addr_hit(shreg[7:1], addr_lo) && !store_busy) begin
                sda_low <= 1'b1;
                rd_mode <= shreg[0];
                state   <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rd_mode) begin
                // Read answer: last command of any kind picks the source
                shreg <= (last_cmd == `WRNC_CMD_RD_CTRL) ?
                         {12'h000, ctrl} : {6'h00, wiper_pos};
                sda_low <= 1'b1;        // Answer bit 15 is zero either way
                state   <= ST_RD;
              end else begin
                sda_low <= 1'b0;
                state   <= ST_WR;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              shreg  <= {shreg[14:0], sda_s}; // [RL3]
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              sda_low <= 1'b1;
              state   <= ST_DACK;
              if (byte_idx) begin
                last_cmd <= shreg[`WRNC_CMD_MSB:`WRNC_CMD_LSB];
                case (shreg[`WRNC_CMD_MSB:`WRNC_CMD_LSB])
                  `WRNC_CMD_WR_WIPER: begin
                    // Scratchpad write, gated by unlock bit [RL7] [RL12] [RL14]
                    if (ctrl[`WRNC_CTL_UNLOCK])
                      wiper_pos <= shreg[`WRNC_DATA_W-1:0];
                  end
                  `WRNC_CMD_STORE: begin
                    if (ctrl[`WRNC_CTL_PROG]) begin      // [RL13]
                      store_cnt <= STORE_CYC;            // [RL9]
                      ctrl[`WRNC_CTL_OK] <= 1'b0;
                    end
                  end
                  `WRNC_CMD_RESTORE: begin
                    wiper_pos <= restore_value(fuse_used, fuse_val); // [RL2]
                  end
                  `WRNC_CMD_WR_CTRL: begin
                    ctrl[2:0] <= shreg[2:0];
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
          ST_DACK: begin
            if (scl_fall) begin
              sda_low  <= 1'b0;
              bitcnt   <= 4'h0;
              byte_idx <= ~byte_idx;
              state    <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                // Release for master acknowledge; NACK ends the read
                sda_low <= 1'b0;
                bitcnt  <= bitcnt + 4'h1;
              end else if (bitcnt == 4'h8) begin
                if (sda_d) begin
                  state <= ST_IDLE;
                end else begin
                  bitcnt  <= 4'h0;
                  shreg   <= {shreg[7:0], 8'h00};
                  sda_low <= ~shreg[7];
                end
              end else begin
                sda_low <= ~shreg[4'he - bitcnt]; // Bits 14..8 in turn [RL3]
                bitcnt  <= bitcnt + 4'h1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ==== common/wrnc_regs.vh ====
// Constants for the wiper register and fuse store control block.
// Assumes a 20 MHz ref_clk; included by bare name from rtl files.
`ifndef WRNC_REGS_VH
`define WRNC_REGS_VH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define WRNC_ADDR_HI       5'b01011
`define WRNC_CMD_MSB       13
`define WRNC_CMD_LSB       10
`define WRNC_DATA_W        10

// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define WRNC_CMD_NOP       4'h0
`define WRNC_CMD_WR_WIPER  4'h1
`define WRNC_CMD_RD_WIPER  4'h2
`define WRNC_CMD_STORE     4'h3
`define WRNC_CMD_RESTORE   4'h4
`define WRNC_CMD_WR_CTRL   4'h7
`define WRNC_CMD_RD_CTRL   4'h8

// ----------------------------------------------------------------
// Control bits and reset values
// ----------------------------------------------------------------
`define WRNC_CTL_PROG      0
`define WRNC_CTL_UNLOCK    1
`define WRNC_CTL_RPERF     2
`define WRNC_CTL_OK        3
`define WRNC_CTL_RESET     4'h0
`define WRNC_MIDSCALE      10'h200

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WRNC_CLK_HZ        20000000
`define WRNC_STORE_MS      350
`define WRNC_STORE_CYC     ((`WRNC_CLK_HZ / 1000) * `WRNC_STORE_MS)

`endif

// ==== rtl/wrnc_sync.v ====
// Two flip-flop synchroniser for the serial pins, the address strap and the restore pin.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/10ps

module wrnc_sync #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         nrst,
  // Data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] stage1;

  // First stage feeds only the second; idle bus level is high
  always @(posedge ref_clk) begin
    if (!nrst) begin
      stage1 <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

// ==== dv/wrnc_top_assertions.sv ====
// Checker for the wiper block: open-drain data line and fuse store timing.
// Assumes a bind to wrnc_top with the same store length parameter.
`timescale 1ns/10ps
module wrnc_top_assertions #(
  parameter STORE_CYC = 7000000
) (
  // Clock and reset
  input wire       ref_clk,
  input wire       nrst,
  // Bus and outputs
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [9:0] wiper_pos,
  input wire       store_busy
);
  // ----------------------------------------
  // Store length counter
  // ----------------------------------------
  reg [31:0] bcnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Busy clocks so far; 32 bits hold a full-length store
  always @(posedge ref_clk) begin
    if (!nrst || !store_busy)
      bcnt <= 32'h0;
    else
      bcnt <= bcnt + 32'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_go;
    !store_busy ##1 store_busy;
  endsequence

  sequence s_end;
    store_busy ##1 !store_busy;
  endsequence

  sda_pull_a: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed with clock high");
  busy_start_a: assert property (s_go |-> sda_oe || $past(sda_oe) || $past(sda_oe, 2))
    else $error("store began outside a command");
  busy_len_a: assert property (s_end |-> bcnt == STORE_CYC)
    else $error("store length wrong");
  busy_max_a: assert property (bcnt <= STORE_CYC)
    else $error("store ran too long");
  busy_wiper_a: assert property (store_busy && $past(store_busy) |-> $stable(wiper_pos))
    else $error("wiper moved during store");
  busy_noack_a: assert property (bcnt > 32'h40 |-> !sda_oe)
    else $error("acknowledge during store");
  rst_quiet_a: assert property ($rose(nrst) |-> !sda_oe && !store_busy)
    else $error("not idle after reset");
endmodule

// ==== dv/wrnc_master.sv ====
// Bus master model for the two-wire slave of the wiper block.
// Assumes the bench forms sda as a pulled-up wired AND of both ends.
`timescale 1ns/10ps
module wrnc_master #(
  parameter Q = 8
) (
  // Clock
  input wire ref_clk,
  // Bus pins
  input wire sda,
  output reg scl,
  output reg sda_drv
);
  // ----------------------------------------
  // Bit and byte level
  // ----------------------------------------
  // Clock stands high and data released between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Changes land just after an edge, never on it
  task tk(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask

  // Data moves only with the clock low
  task bt(input b, output r);
    begin
      tk(Q);
      sda_drv = b;
      tk(Q);
      scl = 1'b1;
      tk(Q);
      r = sda;
      tk(Q);
      scl = 1'b0;
    end
  endtask

  // Eight bits msb first, then the acknowledge slot
  task by(input [7:0] d, input ai, output [7:0] r, output ak);
    integer i;
    reg x;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bt(d[i], r[i]);
      bt(ai, x);
      ak = ~x;
    end
  endtask

  // Start and stop both change data with the clock high
  task frame_start;
    begin
      sda_drv = 1'b0;
      tk(Q);
      scl = 1'b0;
    end
  endtask

  task frame_stop;
    begin
      tk(Q);
      sda_drv = 1'b0;
      tk(Q);
      scl = 1'b1;
      tk(Q);
      sda_drv = 1'b1;
      tk(Q);
    end
  endtask

  // ----------------------------------------
  // Frames
  // ----------------------------------------
  // Gives up after the address when it is not acknowledged
  task wframe(input [6:0] a7, input [15:0] w, output ak);
    reg [7:0] r;
    reg x;
    begin
      frame_start;
      by({a7, 1'b0}, 1'b1, r, ak);
      if (ak) begin
        by(w[15:8], 1'b1, r, x);
        by(w[7:0], 1'b1, r, x);
      end
      frame_stop;
    end
  endtask

  // Acknowledges the first byte, not the last
  task rframe(input [6:0] a7, output [15:0] d, output ak);
    reg x;
    begin
      frame_start;
      by({a7, 1'b1}, 1'b1, d[15:8], ak);
      if (ak) begin
        by(8'hff, 1'b0, d[15:8], x);
        by(8'hff, 1'b1, d[7:0], x);
      end
      frame_stop;
    end
  endtask
endmodule

// ==== dv/test_wiper_register_nvm_control.sv ====
// Bench for the wiper block: bus frames, protection, store and restore.
// Assumes the master model and a short store length for simulation.
`timescale 1ns/10ps
`include "wrnc_regs.vh"

bind wrnc_top wrnc_top_assertions #(.STORE_CYC(STORE_CYC)) chk_i (
  .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .wiper_pos(wiper_pos), .store_busy(store_busy));

module test_wiper_register_nvm_control;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam SC = 2000;
  reg        ref_clk;
  reg        nrst;
  reg        restore_n;
  reg  [1:0] addr_sel;
  wire       scl;
  wire       sda_drv;
  wire       sda_out;
  wire       sda_oe;
  wire       store_busy;
  wire [9:0] wiper_pos;
  wire       sda = sda_drv & (sda_oe ? sda_out : 1'b1);
  integer    n_errors = 0;
  integer    compares = 0;
  integer    cyc = 0;
  reg        a;
  reg [15:0] d;

  wrnc_top #(.STORE_CYC(SC)) uut (.ref_clk(ref_clk), .nrst(nrst),
    .restore_n(restore_n), .addr_sel(addr_sel), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wiper_pos(wiper_pos),
    .store_busy(store_busy));
  wrnc_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // Hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      results;
    end
  end

  task chk(input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask

  task wr(input [3:0] c, input [9:0] v);
    m.wframe({`WRNC_ADDR_HI, addr_sel}, {2'h0, c, v}, a);
  endtask

  task rd(input [3:0] c);
    begin
      wr(c, 10'h0);
      m.rframe({`WRNC_ADDR_HI, addr_sel}, d, a);
    end
  endtask

  task results;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Writes ignored while the unlock bit is clear
  task t_lock;
    begin
      chk(`WRNC_MIDSCALE, wiper_pos);
      wr(`WRNC_CMD_WR_WIPER, 10'h155);
      chk(1, a);
      chk(`WRNC_MIDSCALE, wiper_pos);
    end
  endtask

  // Back-to-back writes at both ends of the code range
  task t_write;
    begin
      wr(`WRNC_CMD_WR_CTRL, 10'h002);
      wr(`WRNC_CMD_WR_WIPER, 10'h3ff);
      chk(10'h3ff, wiper_pos);
      wr(`WRNC_CMD_WR_WIPER, 10'h000);
      chk(10'h000, wiper_pos);
      wr(`WRNC_CMD_WR_WIPER, 10'h2a5);
      wr(`WRNC_CMD_NOP, 10'h111);
      chk(10'h2a5, wiper_pos);
      rd(`WRNC_CMD_RD_WIPER);
      chk(16'h02a5, d);
    end
  endtask

  // Strap levels 0, 2 and 3: own address answered, neighbours not
  task t_addr;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        if (i != 1) begin
          addr_sel = i[1:0];
          m.tk(8);
          m.wframe({`WRNC_ADDR_HI, addr_sel ^ 2'h1}, 16'h0, a);
          chk(0, a);
          m.wframe({5'h0a, addr_sel}, 16'h0, a);
          chk(0, a);
          wr(`WRNC_CMD_NOP, 10'h0);
          chk(1, a);
        end
      end
      addr_sel = 2'h0;
      m.tk(8);
    end
  endtask

  // Store refused, then stored with polling until answered
  task t_store;
    integer n;
    begin
      wr(`WRNC_CMD_STORE, 10'h0);
      m.tk(8);
      chk(0, store_busy);
      wr(`WRNC_CMD_WR_CTRL, 10'h003);
      wr(`WRNC_CMD_STORE, 10'h0);
      chk(1, store_busy);
      wr(`WRNC_CMD_WR_WIPER, 10'h000);
      chk(0, a);
      chk(10'h2a5, wiper_pos);
      n = 0;
      a = 1'b0;
      while (!a && n < 20) begin
        wr(`WRNC_CMD_NOP, 10'h0);
        n = n + 1;
      end
      chk(1, a);
      chk(0, store_busy);
      rd(`WRNC_CMD_RD_CTRL);
      chk(16'h000b, d);
    end
  endtask

  // Restore command, restore pin and power-up bring back the stored code
  task t_restore;
    begin
      wr(`WRNC_CMD_WR_WIPER, 10'h011);
      chk(10'h011, wiper_pos);
      wr(`WRNC_CMD_RESTORE, 10'h0);
      chk(10'h2a5, wiper_pos);
      wr(`WRNC_CMD_WR_WIPER, 10'h011);
      chk(10'h011, wiper_pos);
      restore_n = 1'b0;
      m.tk(8);
      restore_n = 1'b1;
      m.tk(8);
      chk(10'h2a5, wiper_pos);
      nrst = 1'b0;
      m.tk(5);
      nrst = 1'b1;
      m.tk(8);
      chk(10'h2a5, wiper_pos);
    end
  endtask

  // Main sequence
  initial begin
    ref_clk   = 1'b0;
    nrst      = 1'b0;
    restore_n = 1'b1;
    addr_sel  = 2'h0;
    m.tk(5);
    nrst = 1'b1;
    m.tk(4);
    t_lock;
    t_write;
    t_addr;
    t_store;
    t_restore;
    results;
  end
endmodule
